// [adc_pkg.sv]
package adc_pkg;

  // ********************************
  // Geometry
  // ********************************
  localparam int ADDR_W = 20;
  localparam int HALF_W = 10;
  localparam int ROW_LSB = 10;
  localparam int REF_ROW_W = 9;
  localparam int REF_ROWS = 512;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RP_NS = 60;
  localparam int T_RAS_NS = 80;
  localparam int T_RCD_NS = 20;
  localparam int T_CAS_NS = 20;
  localparam int T_CP_NS = 10;
  localparam int T_CAC_NS = 40;
  localparam int T_CSR_NS = 10;
  localparam int T_REF_MS = 8;
  localparam int T_PWRUP_US = 100;
  localparam int WAKE_CYCLES = 8;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CP_CYC = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAC_CYC = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSR_CYC = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CYC = T_PWRUP_US * 1000 / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = T_REF_MS * 1000000 / CLK_PERIOD_NS / REF_ROWS;
  localparam int TMR_W = 16;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    ADC_OP_READ,
    ADC_OP_WRITE,
    ADC_OP_RMW
  } adc_op_t;

  typedef struct packed {
    adc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic wdata;
  } adc_req_t;

  typedef struct packed {
    logic [HALF_W-1:0] multiplexed_address_bus;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_select_n;
    logic input_bit;
  } adc_pins_t;

endpackage : adc_pkg

// [adc_timer.sv]
`timescale 1ns/1ps
module adc_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Load and status
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Load left out here: it is decoded from done, which would form a loop
  assign done = (cnt_q == '0);

endmodule : adc_timer

// [adc_ctrl.sv]
`timescale 1ns/1ps
module adc_ctrl #(
  parameter int PWRUP_CYCLES = adc_pkg::PWRUP_CYC,
  parameter int REF_INTERVAL = adc_pkg::REF_INT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // User requests
  input wire logic req_valid,
  input wire adc_pkg::adc_req_t req,
  input wire logic req_last,
  output logic req_ready,
  output logic rdata_valid,
  output logic rdata,
  output logic init_done,
  // Memory pins
  output adc_pkg::adc_pins_t pins,
  input wire logic output_bit
);

  // ********************************
  // State
  // ********************************
  typedef enum logic [3:0] {
    S_PWRUP, S_WAKE_LO, S_PRE, S_IDLE, S_ROW, S_COL, S_CAS_HI,
    S_WE_LATE, S_REF_CAS, S_REF_RAS
  } adc_state_t;

  adc_state_t st_q, st_d;
  adc_pkg::adc_pins_t pins_q, pins_d;
  adc_pkg::adc_req_t cur_q, cur_d;
  logic [adc_pkg::HALF_W-1:0] row_q, row_d;
  logic [3:0] wake_q, wake_d;
  logic ref_due_q, ref_due_d;
  logic [31:0] ref_cnt_q, ref_cnt_d;
  logic rd_v_q, rd_v_d, rd_q, rd_d;
  logic tmr_load;
  logic [adc_pkg::TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic [31:0] pwr_q, pwr_d;
  logic req_last_q, req_last_d;

  function automatic logic [adc_pkg::TMR_W-1:0] cyc(input int n);
    cyc = adc_pkg::TMR_W'(n - 1);
  endfunction : cyc

  adc_timer #(.W(adc_pkg::TMR_W)) adc_timer_inst (
    .clk(clk),
    .nrst(nrst),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  // ********************************
  // Sequencer
  // ********************************
  always_comb begin
    st_d = st_q;
    pins_d = pins_q;
    cur_d = cur_q;
    row_d = row_q;
    wake_d = wake_q;
    pwr_d = pwr_q;
    rd_v_d = 1'b0;
    rd_d = rd_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    ref_cnt_d = ref_cnt_q + 32'h1;
    ref_due_d = ref_due_q;
    case (st_q)
      S_PWRUP: begin
        if (pwr_q >= 32'(PWRUP_CYCLES - 1)) begin
          st_d = S_PRE;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::RP_CYC);
        end else begin
          pwr_d = pwr_q + 32'h1;
        end
      end
      S_PRE: begin
        if (tmr_done) begin
          if (wake_q != 4'(adc_pkg::WAKE_CYCLES)) begin
            pins_d.row_strobe_n = 1'b0;
            wake_d = wake_q + 4'h1;
            st_d = S_WAKE_LO;
            tmr_load = 1'b1;
            tmr_val = cyc(adc_pkg::RAS_CYC);
          end else begin
            st_d = S_IDLE;
          end
        end
      end
      S_WAKE_LO: begin
        if (tmr_done) begin
          pins_d.row_strobe_n = 1'b1;
          st_d = S_PRE;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::RP_CYC);
        end
      end
      S_IDLE: begin
        if (ref_due_q) begin
          ref_due_d = 1'b0;
          pins_d.column_strobe_n = 1'b0;
          st_d = S_REF_CAS;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::CSR_CYC);
        end else if (req_valid) begin
          cur_d = req;
          row_d = req.addr[adc_pkg::ADDR_W-1:adc_pkg::ROW_LSB];
          pins_d.multiplexed_address_bus = req.addr[adc_pkg::ADDR_W-1:adc_pkg::ROW_LSB];
          pins_d.row_strobe_n = 1'b0;
          st_d = S_ROW;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::RCD_CYC);
        end
      end
      S_ROW: begin
        if (tmr_done) begin
          pins_d.multiplexed_address_bus = cur_q.addr[adc_pkg::HALF_W-1:0];
          pins_d.input_bit = cur_q.wdata;
          // Early write keeps output off and latches data at column fall
          pins_d.write_select_n = (cur_q.op != adc_pkg::ADC_OP_WRITE);
          pins_d.column_strobe_n = 1'b0;
          st_d = S_COL;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::CAC_CYC);
        end
      end
      S_COL: begin
        if (tmr_done) begin
          if (cur_q.op != adc_pkg::ADC_OP_WRITE) begin
            rd_v_d = 1'b1;
            rd_d = output_bit;
          end
          if (cur_q.op == adc_pkg::ADC_OP_RMW) begin
            // Late fall only after data is out, avoiding undefined output
            pins_d.write_select_n = 1'b0;
            st_d = S_WE_LATE;
            tmr_load = 1'b1;
            tmr_val = cyc(adc_pkg::CAS_CYC);
          end else begin
            pins_d.column_strobe_n = 1'b1;
            st_d = S_CAS_HI;
            tmr_load = 1'b1;
            tmr_val = cyc(adc_pkg::CP_CYC);
          end
        end
      end
      S_WE_LATE: begin
        if (tmr_done) begin
          pins_d.column_strobe_n = 1'b1;
          st_d = S_CAS_HI;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::CP_CYC);
        end
      end
      S_CAS_HI: begin
        if (tmr_done) begin
          pins_d.write_select_n = 1'b1;
          // Page hit stays on the open row; a due refresh closes the row instead
          if (req_valid && !cur_q.op[1] && req.addr[adc_pkg::ADDR_W-1:adc_pkg::ROW_LSB] == row_q
              && !req_last_q && !ref_due_q) begin
            cur_d = req;
            st_d = S_ROW;
            tmr_load = 1'b1;
            tmr_val = cyc(1);
          end else begin
            pins_d.row_strobe_n = 1'b1;
            st_d = S_PRE;
            tmr_load = 1'b1;
            tmr_val = cyc(adc_pkg::RP_CYC);
          end
        end
      end
      S_REF_CAS: begin
        if (tmr_done) begin
          pins_d.row_strobe_n = 1'b0;
          st_d = S_REF_RAS;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::RAS_CYC);
        end
      end
      S_REF_RAS: begin
        if (tmr_done) begin
          pins_d.row_strobe_n = 1'b1;
          pins_d.column_strobe_n = 1'b1;
          st_d = S_PRE;
          tmr_load = 1'b1;
          tmr_val = cyc(adc_pkg::RP_CYC);
        end
      end
      default: begin
        st_d = S_PWRUP;
      end
    endcase
    // Tick applied last: a clear in the same cycle must not lose it
    if (ref_cnt_q >= 32'(REF_INTERVAL - 1)) begin
      ref_cnt_d = '0;
      ref_due_d = 1'b1;
    end
  end

  // Last flag is remembered per accepted request
  always_comb begin
    req_last_d = req_last_q;
    if (req_ready && req_valid) begin
      req_last_d = req_last;
    end
  end

  assign req_ready = ((st_q == S_IDLE) && !ref_due_q)
    || ((st_q == S_CAS_HI) && tmr_done && req_valid && !cur_q.op[1] && !req_last_q && !ref_due_q
        && req.addr[adc_pkg::ADDR_W-1:adc_pkg::ROW_LSB] == row_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= S_PWRUP;
      pins_q <= '{multiplexed_address_bus: '0, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                  write_select_n: 1'b1, input_bit: 1'b0};
      cur_q <= '0;
      row_q <= '0;
      wake_q <= '0;
      pwr_q <= '0;
      rd_v_q <= 1'b0;
      rd_q <= 1'b0;
      ref_cnt_q <= '0;
      ref_due_q <= 1'b0;
      req_last_q <= 1'b1;
    end else begin
      st_q <= st_d;
      pins_q <= pins_d;
      cur_q <= cur_d;
      row_q <= row_d;
      wake_q <= wake_d;
      pwr_q <= pwr_d;
      rd_v_q <= rd_v_d;
      rd_q <= rd_d;
      ref_cnt_q <= ref_cnt_d;
      ref_due_q <= ref_due_d;
      req_last_q <= req_last_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign pins = pins_q;
  assign rdata_valid = rd_v_q;
  assign rdata = rd_q;
  assign init_done = (st_q != S_PWRUP) && (st_q != S_WAKE_LO)
    && (wake_q == 4'(adc_pkg::WAKE_CYCLES));

endmodule : adc_ctrl

// [adc_monitor.sv]
`timescale 1ns/1ps
// ********************************
// Controller pin checker
// ********************************
module adc_monitor #(
  parameter int PWRUP_CYCLES = 10,
  parameter int REF_INTERVAL = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // User side
  input wire logic req_valid,
  input wire adc_pkg::adc_req_t req,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic rdata_valid,
  input wire logic rdata,
  input wire logic init_done,
  // Memory side
  input wire adc_pkg::adc_pins_t pins,
  input wire logic output_bit
);
  logic ras, cas, ras_q;
  logic [9:0] rw_q, rw_d;
  logic [15:0] hi_q, hi_d, gap_q, gap_d;
  logic [3:0] wk_q, wk_d;
  adc_pkg::adc_req_t tk_q, tk_d;
  assign ras = pins.row_strobe_n;
  assign cas = pins.column_strobe_n;
  always_comb begin
    tk_d = (req_valid && req_ready) ? req : tk_q;
    rw_d = (ras_q && !ras) ? pins.multiplexed_address_bus : rw_q;
    hi_d = ras ? hi_q + 16'h1 : 16'h0;
    gap_d = (!init_done || (ras_q && !ras && !cas)) ? 16'h0 : gap_q + 16'h1;
    wk_d = (ras_q && !ras && cas && !init_done) ? wk_q + 4'h1 : wk_q;
  end
  // Precharge counter starts at 255: strobes sit high through reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tk_q <= '0;
      rw_q <= 10'h0;
      hi_q <= 16'h00FF;
      gap_q <= 16'h0;
      wk_q <= 4'h0;
      ras_q <= 1'b1;
    end else begin
      tk_q <= tk_d;
      rw_q <= rw_d;
      hi_q <= hi_d;
      gap_q <= gap_d;
      wk_q <= wk_d;
      ras_q <= ras;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ready_after_init: assert property (req_ready |-> init_done)
    else $error("request accepted before wake-up");
  chk_wake_count: assert property ($rose(init_done) |-> wk_q == 4'h8)
    else $error("wake-up row cycles not eight");
  chk_quiet_pwrup: assert property (!init_done |-> cas && pins.write_select_n)
    else $error("column or write active before wake-up end");
  chk_row_addr: assert property ($fell(ras) && cas && init_done
    |-> pins.multiplexed_address_bus == tk_q.addr[19:10])
    else $error("row half wrong");
  chk_col_addr: assert property ($fell(cas) && !ras
    |-> pins.multiplexed_address_bus == tk_q.addr[9:0] && rw_q == tk_q.addr[19:10])
    else $error("column half or open row wrong");
  chk_we_level: assert property ($fell(cas) && !ras
    |-> pins.write_select_n == (tk_q.op != adc_pkg::ADC_OP_WRITE))
    else $error("write select level wrong at column fall");
  chk_ras_prechg: assert property ($fell(ras) |-> hi_q >= 16'(adc_pkg::RP_CYC - 1))
    else $error("row precharge too short");
  chk_refresh_gap: assert property (gap_q < 16'(REF_INTERVAL + 64))
    else $error("refresh interval exceeded");
  chk_cbr_order: assert property ($fell(ras) && !cas |-> $past(cas, 2) == 1'b0)
    else $error("column not settled low before counter refresh");
endmodule : adc_monitor
bind adc_ctrl adc_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES), .REF_INTERVAL(REF_INTERVAL))
  adc_monitor_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
  .req_last(req_last), .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata),
  .init_done(init_done), .pins(pins), .output_bit(output_bit));

// [adc_dram_model.sv]
`timescale 1ns/1ps
// ********************************
// Memory device model
// ********************************
module adc_dram_model (
  // Strobes and data
  input wire adc_pkg::adc_pins_t pins,
  output logic output_bit
);
  logic mem [0:1048575];
  logic [9:0] row_q, col_q;
  logic [8:0] rfsh_cnt;
  int rfsh_total;
  logic drv, dout, rd_pend;
  initial begin
    drv = 1'b0;
    rd_pend = 1'b0;
    dout = 1'b0;
    rfsh_cnt = 9'h0;
    rfsh_total = 0;
    row_q = 10'h0;
    col_q = 10'h0;
  end
  // Released pin shows inverse of last value, never a stale copy
  assign output_bit = drv ? dout : ~dout;
  // Output left alone at row fall: old data survives a low column
  always @(negedge pins.row_strobe_n) begin
    if (pins.column_strobe_n) begin
      row_q = pins.multiplexed_address_bus;
    end else begin
      row_q = {1'b0, rfsh_cnt};
      rfsh_cnt = rfsh_cnt + 9'h1;
      rfsh_total++;
    end
  end
  always @(negedge pins.column_strobe_n) begin
    if (!pins.row_strobe_n) begin
      col_q = pins.multiplexed_address_bus;
      if (!pins.write_select_n) begin
        mem[{row_q, col_q}] = pins.input_bit;
      end else begin
        rd_pend = 1'b1;
        #20;
        if (!pins.column_strobe_n) begin
          dout = rd_pend ? mem[{row_q, col_q}] : 1'bx;
          drv = 1'b1;
        end
        rd_pend = 1'b0;
      end
    end
  end
  // Late write after data is out keeps output; before it, output undefined
  always @(negedge pins.write_select_n) begin
    if (!pins.column_strobe_n && (drv || rd_pend)) begin
      mem[{row_q, col_q}] = pins.input_bit;
      rd_pend = 1'b0;
    end
  end
  always @(posedge pins.column_strobe_n) begin
    drv = 1'b0;
  end
endmodule : adc_dram_model

// [tb_top.sv]
`timescale 1ns/1ps
// ********************************
// Controller testbench
// ********************************
module tb_top;
  localparam int RI = 200;
  logic clk, nrst, req_valid, req_last, req_ready, rdata_valid, rdata, init_done, output_bit;
  adc_pkg::adc_req_t req;
  adc_pkg::adc_pins_t pins;
  int mismatches, compares;
  logic [19:0] ta [4] = '{20'hFFC01, 20'h7FC01, 20'h003FF, 20'h556AA};
  logic [3:0] td = 4'b0101;
  adc_ctrl #(.PWRUP_CYCLES(10), .REF_INTERVAL(RI)) adc_ctrl_inst (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req(req), .req_last(req_last), .req_ready(req_ready),
    .rdata_valid(rdata_valid), .rdata(rdata), .init_done(init_done), .pins(pins),
    .output_bit(output_bit));
  adc_dram_model adc_dram_model_inst (.pins(pins), .output_bit(output_bit));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task check(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Waits are bounded so a stuck handshake ends as a mismatch
  task wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((which == 0 ? req_ready : which == 1 ? rdata_valid : init_done) !== 1'b1
               && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      $display("ERROR %0t handshake wait expired", $time);
    end
  endtask : wait_for
  task send(input logic [1:0] op, input logic [19:0] a, input logic d, input logic last);
    req_valid <= 1'b1;
    req <= '{adc_pkg::adc_op_t'(op), a, d};
    req_last <= last;
    wait_for(0);
  endtask : send
  task rd(input logic [19:0] a, input logic last);
    send(2'h0, a, 1'b0, last);
    req_valid <= 1'b0;
    wait_for(1);
  endtask : rd
  task t_init;
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      check(req_ready, 1'b0);
      @(posedge clk);
      n++;
    end
    check(init_done, 1'b1);
    check(n > 280, 1'b1);
    $display("test init done");
  endtask : t_init
  task t_rw;
    // Valid stays up: the first read follows at once
    for (int i = 0; i < 4; i++) send(2'h1, ta[i], td[i], 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(ta[i], 1'b1);
      check(rdata, td[i]);
    end
    $display("test read write done");
  endtask : t_rw
  task t_page;
    for (int c = 0; c < 4; c++) send(2'h1, {10'h0A5, 10'(c)}, c[1], c == 3);
    for (int c = 3; c >= 0; c--) begin
      rd({10'h0A5, 10'(c)}, c == 0);
      check(rdata, c[1]);
    end
    rd(ta[3], 1'b1);
    check(rdata, td[3]);
    $display("test page done");
  endtask : t_page
  task t_rmw;
    send(2'h2, ta[0], 1'b0, 1'b1);
    req_valid <= 1'b0;
    wait_for(1);
    check(rdata, td[0]);
    rd(ta[0], 1'b1);
    check(rdata, 1'b0);
    $display("test read modify write done");
  endtask : t_rmw
  task t_refresh;
    int n0;
    n0 = adc_dram_model_inst.rfsh_total;
    repeat (3 * RI) @(posedge clk);
    check(adc_dram_model_inst.rfsh_total - n0 >= 2, 1'b1);
    rd(ta[2], 1'b1);
    check(rdata, td[2]);
    $display("test refresh done");
  endtask : t_refresh
  task t_reset;
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    check(init_done, 1'b0);
    nrst <= 1'b1;
    t_init;
    rd(ta[2], 1'b1);
    check(rdata, td[2]);
    $display("test second reset done");
  endtask : t_reset
  initial begin
    #(4 * 30000);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    req_last = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_init;
    t_rw;
    t_page;
    t_rmw;
    t_refresh;
    t_reset;
    finish_test;
  end
endmodule : tb_top
